// ===== hw/cprc_defs.svh
// Constants for the clock, power and reset controller.
// Assumes inclusion by bare name from the design module.
`ifndef CPRC_DEFS_SVH
`define CPRC_DEFS_SVH
`define CPRC_PWR_CTRL_ADDR  8'h87
`define CPRC_BIT_IDLE       0
`define CPRC_BIT_PDOWN      1
`define CPRC_BIT_USER0      2
`define CPRC_BIT_USER1      3
`define CPRC_BIT_COLD       4
`define CPRC_PWR_CTRL_POR   8'h10
`define CPRC_COLD_MASK      8'h10
`define CPRC_PORT_RESET     8'hFF
`define CPRC_SP_RESET       8'h07
`define CPRC_SFR_RESET      8'h00
`define CPRC_CLK_DIV        2
`define CPRC_STATES_PER_MC  6
`define CPRC_PHASES_PER_MC  12
`define CPRC_SAMPLE_PHASE   9
`define CPRC_RESET_MC       2
`endif

// ===== hw/cprc_pkg.sv
// Types for the clock, power and reset controller.
// Uses nothing from the constants header and includes no file.
package cprc_pkg;
  // Power modes of the core.
  typedef enum logic [1:0] {
    CPRC_RUN   = 2'b00,
    CPRC_IDLE  = 2'b01,
    CPRC_PDOWN = 2'b10
  } cprc_mode_t;
endpackage

// ===== hw/cprc_ctrl.sv
// Clock gating, power modes, reset sampling and code protection control.
// Assumes clk_in is the oscillator input and one SFR write port from core.
`timescale 1ns/10ps
`include "cprc_defs.svh"

module cprc_ctrl
  import cprc_pkg::*;
#(
  parameter int DIV   = `CPRC_CLK_DIV,
  parameter int RST_MC = `CPRC_RESET_MC
) (
  // Clock and synchronous power-on reset.
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // External reset pin, active high, asynchronous.
  input  wire logic       ext_reset_in,
  // Special-function register write port from the core.
  input  wire logic       sfr_wr_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic [7:0] sfr_wdata_in,
  // Enabled interrupt request from the interrupt logic.
  input  wire logic       irq_pending_in,
  // Code table read check.
  input  wire logic       ctr_req_in,
  input  wire logic       ctr_from_internal_in,
  input  wire logic       ctr_target_internal_in,
  input  wire logic       read_inhibit_bit_in,
  // Encryption bit control and port 0 data.
  input  wire logic       encrypt_program_in,
  input  wire logic       chip_erase_in,
  input  wire logic [7:0] p0_data_in,
  input  wire logic [7:0] encrypt_key_in,
  // Clock enables to the core and peripherals.
  output logic            phase_clk_out,
  output logic            cpu_clk_en_out,
  output logic            periph_clk_en_out,
  output logic            osc_enable_out,
  output logic            state5_phase2_slot_out,
  // Reset to the rest of the chip and power status.
  output logic            sys_reset_out,
  output logic [7:0]      power_control_register_out,
  output logic [7:0]      port_latch_out,
  output logic [7:0]      stack_ptr_out,
  output logic            clear_sfrs_out,
  // Code protection results.
  output logic            ctr_allow_out,
  output logic [7:0]      p0_drive_out,
  output logic            encrypt_en_out
);

  // Refuse a divider other than two and too short a reset hold.
  initial begin
    if (DIV != 2 || RST_MC < 1) begin
      $error("cprc_ctrl: unsupported parameter");
    end
  end

  logic [1:0] rst_sync_ff;      // Pin synchroniser for the external reset.
  logic       div_ff;           // Divide-by-two toggle.
  logic [3:0] phase_ff;         // Phase index within a machine cycle.
  logic [3:0] rst_cnt_ff;       // Consecutive high samples of reset.
  logic       sys_rst_ff;       // Filtered reset state.
  cprc_mode_t mode_ff;          // Current power mode.
  logic [7:0] pwrctl_ff;        // Power control register.
  logic [7:0] port_ff;          // Port latch image.
  logic [7:0] sp_ff;            // Stack pointer image.
  logic       enc_ff;           // Nonvolatile encryption enable.
  logic       allow_ff;         // Registered code table permission.
  logic [7:0] p0_ff;            // Registered port 0 drive.
  logic       slot_ff;          // Sampling slot marker.
  logic       pwrctl_wr;        // Software write to power control.
  logic       slot;             // Sampling instant this clock.

  // The machine cycle is twelve phases of the divided clock. The reset
  // pin is looked at only once per machine cycle, in the fixed sampling
  // slot, so a pulse shorter than a machine cycle can slip between two
  // samples and is never seen at all.
  // A reset source must therefore hold the pin for whole machine cycles.
  // In power-down the divided clock stands still, so the sampling slot
  // never comes round; the synchronised pin is then used directly to
  // start the reset, and the slot filter decides when it ends.
  // The encryption bit models a nonvolatile cell, so it has no reset of
  // its own and keeps its value across every kind of reset.

  // Decode a write to the power control register.
  assign pwrctl_wr = sfr_wr_in && sfr_addr_in == `CPRC_PWR_CTRL_ADDR;
  // The sampling slot is one phase per machine cycle.
  assign slot = div_ff && phase_ff == 4'(`CPRC_SAMPLE_PHASE);

  // Synchronise the reset pin before any logic reads it.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], ext_reset_in};
    end
  end

  // Divide the oscillator by two and count phases; halt in power-down.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      div_ff   <= 1'b0;
      phase_ff <= 4'h0;
    end else if (mode_ff != CPRC_PDOWN || sys_rst_ff) begin
      div_ff <= ~div_ff;
      if (div_ff) begin
        if (phase_ff == 4'(`CPRC_PHASES_PER_MC - 1)) begin
          phase_ff <= 4'h0;
        end else begin
          phase_ff <= phase_ff + 4'h1;
        end
      end
    end
  end

  // Sample reset once per machine cycle and need several highs in a row.
  // In power-down the phase clock stops, so the synchronised pin must wake the
  // oscillator; the filter then qualifies it once clocks run again.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rst_cnt_ff <= 4'h0;
      sys_rst_ff <= 1'b1;
    end else if (mode_ff == CPRC_PDOWN && rst_sync_ff[1]) begin
      sys_rst_ff <= 1'b1;
      rst_cnt_ff <= 4'h0;
    end else if (slot) begin
      if (!rst_sync_ff[1]) begin
        rst_cnt_ff <= 4'h0;
        sys_rst_ff <= 1'b0;
      end else if (rst_cnt_ff >= 4'(RST_MC - 1)) begin
        sys_rst_ff <= 1'b1;
      end else begin
        rst_cnt_ff <= rst_cnt_ff + 4'h1;
      end
    end
  end

  // Power mode machine. Any reset returns the core to run mode, which is
  // also the only way out of power-down.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || sys_rst_ff) begin
      // Any reset ends idle and power-down alike.
      mode_ff <= CPRC_RUN;
    end else begin
      case (mode_ff)
        // Running: a power control write may stop clocks.
        CPRC_RUN: begin
          if (pwrctl_wr && sfr_wdata_in[`CPRC_BIT_PDOWN]) begin
            // Power-down wins when both request bits are written.
            mode_ff <= CPRC_PDOWN;
          end else if (pwrctl_wr && sfr_wdata_in[`CPRC_BIT_IDLE]) begin
            // Idle stops only the core clock.
            mode_ff <= CPRC_IDLE;
          end
        end
        // Idle: any enabled interrupt wakes the core.
        CPRC_IDLE: begin
          if (irq_pending_in) begin
            mode_ff <= CPRC_RUN;
          end
        end
        // Power-down: interrupts are ignored, only reset leaves it.
        CPRC_PDOWN: begin
          mode_ff <= CPRC_PDOWN;
        end
        // Unused code: recover to run mode.
        default: begin
          mode_ff <= CPRC_RUN;
        end
      endcase
    end
  end

  // Power control register. The cold boot flag is set by power-on reset
  // or a software write; a pin reset clears the other bits and keeps that flag, so
  // software can tell a warm start from a cold one.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      // Power-on: only the cold boot flag is set.
      pwrctl_ff <= `CPRC_PWR_CTRL_POR;
    end else if (sys_rst_ff) begin
      // Pin reset: clear every bit except the cold boot flag.
      pwrctl_ff <= `CPRC_SFR_RESET | (pwrctl_ff & `CPRC_COLD_MASK);
    end else if (pwrctl_wr) begin
      // Software write, which also lets software clear the cold flag.
      pwrctl_ff <= sfr_wdata_in;
    end else if (mode_ff == CPRC_IDLE && irq_pending_in) begin
      // Waking from idle drops the request so the core stays awake.
      pwrctl_ff[`CPRC_BIT_IDLE] <= 1'b0;
    end
  end

  // Port latches and stack pointer images forced during reset.
  // Outside reset the core owns these registers; here they only hold.
  // The serial buffer is not touched by reset and is not modelled.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || sys_rst_ff) begin
      // Ports to all ones, stack pointer to seven.
      port_ff <= `CPRC_PORT_RESET;
      sp_ff   <= `CPRC_SP_RESET;
    end else begin
      port_ff <= port_ff;
      sp_ff   <= sp_ff;
    end
  end

  // Encryption bit: set by programming, cleared only by chip erase.
  // It models a nonvolatile cell, so no reset of any kind touches it.
  // Erase wins when both strobes arrive together.
  always_ff @(posedge clk_in) begin
    if (chip_erase_in) begin
      // Whole-chip erase is the only way to clear it.
      enc_ff <= 1'b0;
    end else if (encrypt_program_in) begin
      enc_ff <= 1'b1;
    end
  end

  // Code table read permission and port 0 encoding.
  // A read from internal code, or with the inhibit bit set, may reach
  // anything; a read from external code may only reach external code.
  // Encoding is an exclusive-or with the key, so it is undone the same
  // way by whoever holds the key.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      allow_ff <= 1'b0;
      p0_ff    <= `CPRC_PORT_RESET;
      slot_ff  <= 1'b0;
    end else begin
      slot_ff  <= slot;
      if (read_inhibit_bit_in || ctr_from_internal_in) begin
        allow_ff <= ctr_req_in;
      end else begin
        allow_ff <= ctr_req_in && !ctr_target_internal_in;
      end
      p0_ff <= enc_ff ? (p0_data_in ^ encrypt_key_in) : p0_data_in;
    end
  end

  // Registered clock enables and status.
  // The core and peripheral enables pulse once per divided clock; the core enable drops in
  // idle and power-down, the peripheral enable only in power-down, and
  // the oscillator enable falls in power-down to stop the oscillator.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cpu_clk_en_out    <= 1'b0;
      periph_clk_en_out <= 1'b0;
      osc_enable_out    <= 1'b1;
    end else begin
      cpu_clk_en_out    <= div_ff && mode_ff == CPRC_RUN;
      periph_clk_en_out <= div_ff && mode_ff != CPRC_PDOWN;
      osc_enable_out    <= mode_ff != CPRC_PDOWN;
    end
  end

  // Every output below is a plain copy of a register.
  assign phase_clk_out              = div_ff;
  assign state5_phase2_slot_out     = slot_ff;
  assign sys_reset_out              = sys_rst_ff;
  assign clear_sfrs_out             = sys_rst_ff;
  assign power_control_register_out = pwrctl_ff;
  assign port_latch_out             = port_ff;
  assign stack_ptr_out              = sp_ff;
  assign ctr_allow_out              = allow_ff;
  assign p0_drive_out               = p0_ff;
  assign encrypt_en_out             = enc_ff;

endmodule

// ===== dv/cprc_monitor.sv
// Assertion checker for the clock, power and reset controller.
// Assumes it is bound to cprc_ctrl and sees only that module's ports.
`timescale 1ns/10ps
module cprc_monitor (
  // Clock, resets and the inputs that the checks depend on.
  input wire logic       clk_in, reset_n_in, ext_reset_in, sfr_wr_in,
  input wire logic       irq_pending_in, ctr_req_in, ctr_from_internal_in,
  input wire logic       ctr_target_internal_in, read_inhibit_bit_in,
  input wire logic       chip_erase_in,
  input wire logic [7:0] p0_data_in, encrypt_key_in,
  // Outputs of the controller under watch.
  input wire logic       cpu_clk_en_out, periph_clk_en_out, osc_enable_out,
  input wire logic       state5_phase2_slot_out, sys_reset_out,
  input wire logic       phase_clk_out,
  input wire logic       clear_sfrs_out, ctr_allow_out, encrypt_en_out,
  input wire logic [7:0] power_control_register_out, port_latch_out,
  input wire logic [7:0] stack_ptr_out, p0_drive_out
);
  logic [7:0] pc; // Short alias of the power control register.
  assign pc = power_control_register_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_reset_values: assert property (
    sys_reset_out [*2] |-> port_latch_out == 8'hFF && clear_sfrs_out &&
    stack_ptr_out == 8'h07 && pc[3:0] == 4'h0) else $error("reset value");
  a_idle_gate: assert property (
    pc[0] && $past(pc[0]) && !pc[1] |-> !cpu_clk_en_out) else $error("idle");
  a_pdown_stops: assert property (
    pc[1] && $past(pc[1]) |-> !osc_enable_out && !periph_clk_en_out)
    else $error("power-down clocks");
  a_irq_wakes: assert property (
    pc[0] && !pc[1] && irq_pending_in && !sfr_wr_in && !sys_reset_out
    |=> !pc[0]) else $error("idle wake");
  a_pdown_holds: assert property (
    (!ext_reset_in) [*3] ##0 (pc[1] && irq_pending_in && !sfr_wr_in &&
    !sys_reset_out) |=> pc[1]) else $error("power-down wake");
  a_read_gate: assert property (
    ctr_req_in |=> ctr_allow_out == $past(read_inhibit_bit_in ||
    ctr_from_internal_in || !ctr_target_internal_in)) else $error("read");
  a_port0_code: assert property (
    $past(reset_n_in) && $stable(encrypt_en_out) |-> p0_drive_out ==
    ($past(p0_data_in) ^ (encrypt_en_out ? $past(encrypt_key_in) : 8'h00)))
    else $error("port 0 data");
  a_encrypt_keep: assert property (
    encrypt_en_out && !chip_erase_in |=> encrypt_en_out) else $error("enc");
  a_slot_gap: assert property (
    state5_phase2_slot_out |=> !state5_phase2_slot_out [*8])
    else $error("slot spacing");
  a_phase_div: assert property (
    !pc[1] |=> phase_clk_out != $past(phase_clk_out)) else $error("divide");
  c_idle_irq: cover property (pc[0] && irq_pending_in);
  c_pdown_irq: cover property (pc[1] && irq_pending_in);
  c_ext_reset: cover property ($rose(sys_reset_out));
endmodule
bind cprc_ctrl cprc_monitor cprc_monitor_inst (.*);

// ===== dv/cprc_rst_src.sv
// Model of the external reset source driving the reset pin.
// Assumes go_in is a one-cycle pulse; the pin idles low (pull-down).
`timescale 1ns/10ps
module cprc_rst_src (
  // Clock and request to hold the pin high for len_in cycles.
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic [7:0] len_in,
  // Reset pin, active high.
  output logic            ext_reset_out
);
  logic [7:0] cnt_ff = 8'h00; // Cycles left with the pin high.
  // A long hold spans two machine cycles; a short one is a glitch.
  always @(posedge clk_in) begin
    if (go_in) cnt_ff <= len_in;
    else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
  end
  assign ext_reset_out = (cnt_ff != 8'h00);
endmodule

// ===== dv/test_clock_power_reset_control.sv
// Self-checking bench for the clock, power and reset controller.
// Assumes the design, reset source model and checker are compiled first.
`timescale 1ns/10ps
module test_clock_power_reset_control;
  logic clk_in, reset_n_in, ext_reset_in, sfr_wr_in, irq_pending_in, go;
  logic ctr_req_in, ctr_from_internal_in, ctr_target_internal_in, hit;
  logic read_inhibit_bit_in, encrypt_program_in, chip_erase_in;
  logic [7:0] sfr_addr_in, sfr_wdata_in, p0_data_in, encrypt_key_in, len;
  logic phase_clk_out, cpu_clk_en_out, periph_clk_en_out, osc_enable_out;
  logic state5_phase2_slot_out, sys_reset_out, clear_sfrs_out;
  logic ctr_allow_out, encrypt_en_out;
  logic [7:0] power_control_register_out, port_latch_out, stack_ptr_out;
  logic [7:0] p0_drive_out;
  logic [15:0] cyc; // Cycle count for the hang guard.
  int error_cnt, checks;
  // Rows: inhibit, from internal, target internal, expected allow.
  logic [3:0] rows [8] = '{4'h1, 4'h2, 4'h5, 4'h7, 4'h9, 4'hB, 4'hD, 4'hF};
  cprc_ctrl cprc_ctrl_inst (.*);
  cprc_rst_src cprc_rst_src_inst (.clk_in, .go_in(go), .len_in(len),
                                  .ext_reset_out(ext_reset_in));
  initial begin clk_in = 0; forever #50 clk_in = ~clk_in; end
  task automatic chk(input string n, input logic [7:0] e, s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // Waits n edges, then lets their updates settle.
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wait_rst(input logic v);
    repeat (200) if (sys_reset_out !== v) cyc_n(1);
    chk("sys_reset", {7'h0, v}, {7'h0, sys_reset_out});
  endtask
  task automatic sfr_write(input logic [7:0] v);
    @(posedge clk_in);
    sfr_wr_in <= 1;
    sfr_wdata_in <= v;
    @(posedge clk_in);
    sfr_wr_in <= 0;
    cyc_n(3);
  endtask
  task automatic irq_pulse;
    @(posedge clk_in);
    irq_pending_in <= 1;
    @(posedge clk_in);
    irq_pending_in <= 0;
    cyc_n(3);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard: the whole run needs well under 1000 cycles.
  always @(posedge clk_in) begin
    cyc <= cyc + 16'h0001;
    if (cyc == 16'h0BB8) begin
      error_cnt++;
      wrap_up;
    end
  end
  initial begin
    {reset_n_in, sfr_wr_in, irq_pending_in, ctr_req_in, go, cyc} = '0;
    {ctr_from_internal_in, ctr_target_internal_in, read_inhibit_bit_in} = '0;
    {encrypt_program_in, chip_erase_in, sfr_wdata_in, len} = '0;
    {sfr_addr_in, p0_data_in, encrypt_key_in} = {8'h87, 8'h5A, 8'hC3};
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1;
    wait_rst(0);
    chk("pwr_ctrl", 8'h10, power_control_register_out);
    chk("port", 8'hFF, port_latch_out);
    chk("sp", 8'h07, stack_ptr_out);
    hit = phase_clk_out;
    cyc_n(1);
    chk("phase", {7'h0, ~hit}, {7'h0, phase_clk_out});
    foreach (rows[i]) begin
      @(posedge clk_in);
      ctr_req_in <= 1;
      {read_inhibit_bit_in, ctr_from_internal_in,
       ctr_target_internal_in} <= rows[i][3:1];
      cyc_n(1);
      chk("allow", {7'h0, rows[i][0]}, {7'h0, ctr_allow_out});
    end
    $display("power-on and read gate tests done");
    @(posedge clk_in);
    ctr_req_in <= 0;
    chip_erase_in <= 1;
    @(posedge clk_in);
    chip_erase_in <= 0;
    encrypt_program_in <= 1;
    @(posedge clk_in);
    encrypt_program_in <= 0;
    cyc_n(2);
    chk("p0", 8'h99, p0_drive_out);
    @(posedge clk_in);
    len <= 8'h03;
    go <= 1;
    @(posedge clk_in);
    go <= 0;
    hit = 0;
    repeat (60) begin cyc_n(1); hit = hit | sys_reset_out; end
    chk("glitch", 8'h00, {7'h0, hit});
    sfr_write(8'h11);
    chk("idle", 8'h11, power_control_register_out);
    chk("cpu_en", 8'h00, {7'h0, cpu_clk_en_out});
    irq_pulse;
    chk("wake", 8'h10, power_control_register_out);
    sfr_write(8'h02);
    chk("osc", 8'h00, {7'h0, osc_enable_out});
    irq_pulse;
    chk("pdown", 8'h02, power_control_register_out);
    @(posedge clk_in);
    len <= 8'h3C;
    go <= 1;
    @(posedge clk_in);
    go <= 0;
    wait_rst(1);
    wait_rst(0);
    chk("pwr_ctrl", 8'h00, power_control_register_out);
    chk("enc", 8'h01, {7'h0, encrypt_en_out});
    $display("power mode and external reset tests done");
    wrap_up;
  end
endmodule
